// [include/tag_cfg_consts.vh]
`ifndef TAG_CFG_CONSTS_VH
`define TAG_CFG_CONSTS_VH

// Serial byte addresses in the system area
`define LOCK_LO_ADDR     12'h800
`define LOCK_HI_ADDR     12'h801
`define CFG_ADDR         12'h910
`define CTRL_ADDR        12'h920

// Delivered-state values
`define LOCK_RESET       16'h0000
`define CFG_RESET        8'hF4

// Configuration byte fields
`define CFG_LVL_LO_BIT   0
`define CFG_LVL_HI_BIT   1
`define CFG_DEF_OFF_BIT  2
`define CFG_PIN_MODE_BIT 3

// Control register fields
`define CTRL_HARVEST_BIT 0
`define CTRL_FIELD_BIT   1
`define CTRL_DONE_BIT    7

// Sector lock field width
`define LOCK_SECTORS     4

// RF command codes
`define CMD_READ_CFG     3'h1
`define CMD_WRITE_HCFG   3'h2
`define CMD_WRITE_PCFG   3'h3
`define CMD_READ_CTRL    3'h4
`define CMD_SET_HARVEST  3'h5

`endif

// [hw/sync_two_flop.v]
`timescale 1ns/1ps
// Two-flop synchroniser for a bundle of independent levels
module sync_two_flop #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input  wire             i_clock,
   input  wire             i_rst,
   // Levels
   input  wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_sync
);
   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] sync_reg;

   // First stage feeds only the second stage
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         meta_reg <= {WIDTH{1'b0}};
         sync_reg <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;
endmodule

// [hw/tag_config_and_write_lock.v]
`timescale 1ns/1ps
`include "tag_cfg_consts.vh"
// Function
// R1: Lock area at 2048; lock, config, control reachable only with system select set.
// R2: Lock bits 3:0 guard sectors 0-3 against serial writes; other bits ignored.
// R3: Serial lock reads always succeed; writes need the serial password presented.
// R4: Both lock bytes are zero when delivered.
// R5: Eight-bit non-volatile configuration byte at serial address 2320.
// R6: Eight-bit volatile control register at serial address 2336.
// R7: Config bit 3 picks pin mode: 0 busy, 1 write in progress.
// R8: Busy mode drives pin low from RF start of frame to end of execution.
// R9: Busy mode, invalid command: pin low only from frame start until its CRC.
// R10: Pin released when the RF field disappears.
// R11: Busy mode keeps pin released during serial command execution.
// R12: Write-in-progress mode: pin low from valid RF write end until answer start.
// R13: Write-in-progress mode keeps pin released during serial writes.
// R14: Config bits 1:0 pick sink level; bit 2 is harvest default-off.
// R15: Config bits 7:4 have no effect.
// R16: Harvest output driven only when enabled and power and load conditions hold.
// R17: Control bits 7:1 read-only; only bit 0 writable.
// R18: Write-done clears at reset and each serial write cycle start; sets on success.
// R19: At power-up harvest enable loads the inverse of default-off.
// R20: Control bit 1 shows RF field power; RF reads return 1 there.
// R21: Serial reads and writes of the config byte need no password.
// R22: RF commands: read config, write bits 2:0, write pin mode bit.
// R23: RF commands: read control register, set or clear harvest enable.
// R24: RF reads of control return write-done as 0.
// R25: New config value applies at once, without power cycle.
// R26: Activity pin is open drain: enable drives 0, otherwise released.
module tag_config_and_write_lock (
   // Clock and reset
   input  wire        i_clock,
   input  wire        i_rst,
   // Non-volatile contents presented at power-up
   input  wire [15:0] i_nv_lock,
   input  wire [7:0]  i_nv_config,
   // Serial byte access port
   input  wire        i_ser_valid,
   input  wire        i_ser_write,
   input  wire        i_system_area_select,
   input  wire [11:0] i_ser_addr,
   input  wire [7:0]  i_ser_wdata,
   input  wire        i_ser_pwd_ok,
   input  wire        i_ser_active,
   input  wire        i_ser_wcycle_start,
   input  wire        i_ser_wcycle_ok,
   output reg         o_ser_ack,
   output reg         o_ser_err,
   output reg  [7:0]  o_ser_rdata,
   // Sector write protection toward the memory array
   output reg  [3:0]  o_sector_locked,
   // Stored values toward the non-volatile store
   output reg  [15:0] o_lock_area,
   output reg  [7:0]  o_config_byte,
   // RF link pins, synchronised to the system clock; events taken at link clock rising edges
   input  wire        i_rf_clk,
   input  wire        i_rf_field,
   input  wire        i_rf_sof,
   input  wire        i_rf_crc_ok,
   input  wire        i_rf_crc_bad,
   input  wire        i_rf_exec_done,
   input  wire        i_rf_write_end,
   input  wire        i_rf_answer_start,
   input  wire        i_rf_cmd_valid,
   input  wire [2:0]  i_rf_cmd,
   input  wire [7:0]  i_rf_wdata,
   output reg         o_rf_ack,
   output reg  [7:0]  o_rf_rdata,
   // Activity pin, open drain
   output reg         o_rf_activity_pin_o,
   output reg         o_rf_activity_pin_oe,
   // Harvest analog conditions and controls
   input  wire        i_harvest_power_ok,
   input  wire        i_harvest_load_ok,
   output reg         o_harvest_drive,
   output reg  [1:0]  o_harvest_level
);
   // Pin state machine, one-hot
   localparam [4:0] ST_LOAD = 5'b0_0001;
   localparam [4:0] ST_IDLE = 5'b0_0010;
   localparam [4:0] ST_RX   = 5'b0_0100;
   localparam [4:0] ST_EXEC = 5'b0_1000;
   localparam [4:0] ST_WIP  = 5'b1_0000;

   wire [17:0] raw_in;
   wire [17:0] syn;
   reg         rf_clk_d_reg;
   reg  [4:0]  state_reg;
   reg  [4:0]  state_next;
   reg  [15:0] lock_reg;
   reg  [7:0]  cfg_reg;
   reg         harvest_on_reg;
   reg         done_reg;

   // Pin inputs gathered for synchronisation
   assign raw_in = {i_rf_clk, i_rf_field, i_rf_sof, i_rf_crc_ok, i_rf_crc_bad,
                    i_rf_exec_done, i_rf_write_end, i_rf_answer_start,
                    i_rf_cmd_valid, i_rf_cmd, i_rf_wdata[3:0],
                    i_harvest_power_ok, i_harvest_load_ok};

   sync_two_flop #(.WIDTH(18)) u_sync (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_async (raw_in),
      .o_sync  (syn)
   );

   wire       s_rf_clk    = syn[17];
   wire       s_field     = syn[16];
   wire       s_sof       = syn[15];
   wire       s_crc_ok    = syn[14];
   wire       s_crc_bad   = syn[13];
   wire       s_done      = syn[12];
   wire       s_wr_end    = syn[11];
   wire       s_ans       = syn[10];
   wire       s_cmd_v     = syn[9];
   wire [2:0] s_cmd       = syn[8:6];
   wire [3:0] s_wdata     = syn[5:2];
   wire       s_h_power   = syn[1];
   wire       s_h_load    = syn[0];

   // Link clock rising edge detect on the synchronised level
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         rf_clk_d_reg <= 1'b0;
      end else begin
         rf_clk_d_reg <= s_rf_clk;
      end
   end

   wire rf_tick  = s_rf_clk & ~rf_clk_d_reg;
   wire pin_mode = cfg_reg[`CFG_PIN_MODE_BIT]; // R7 R25

   // Serial access decode
   wire sys_ok   = i_ser_valid & i_system_area_select; // R1
   wire hit_lo   = sys_ok & (i_ser_addr == `LOCK_LO_ADDR); // R1
   wire hit_hi   = sys_ok & (i_ser_addr == `LOCK_HI_ADDR); // R1
   wire hit_cfg  = sys_ok & (i_ser_addr == `CFG_ADDR); // R5 R21
   wire hit_ctrl = sys_ok & (i_ser_addr == `CTRL_ADDR); // R6
   wire hit_any  = hit_lo | hit_hi | hit_cfg | hit_ctrl;
   wire lock_wr  = (hit_lo | hit_hi) & i_ser_write & i_ser_pwd_ok; // R3
   wire lock_ref = (hit_lo | hit_hi) & i_ser_write & ~i_ser_pwd_ok; // R3

   // RF command decode
   wire rf_cmd     = rf_tick & s_cmd_v & s_field;
   wire rf_wr_hcfg = rf_cmd & (s_cmd == `CMD_WRITE_HCFG); // R22
   wire rf_wr_pcfg = rf_cmd & (s_cmd == `CMD_WRITE_PCFG); // R22
   wire rf_set_h   = rf_cmd & (s_cmd == `CMD_SET_HARVEST); // R23

   // Lock area, loaded from the store then written with password
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         lock_reg <= `LOCK_RESET; // R4
      end else if (state_reg == ST_LOAD) begin
         lock_reg <= i_nv_lock;
      end else if (lock_wr & hit_lo) begin
         lock_reg[7:0] <= i_ser_wdata; // R3
      end else if (lock_wr & hit_hi) begin
         lock_reg[15:8] <= i_ser_wdata; // R3
      end
   end

   // Configuration byte, serial writes any bit, RF writes its fields
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cfg_reg <= `CFG_RESET;
      end else if (state_reg == ST_LOAD) begin
         cfg_reg <= i_nv_config;
      end else if (hit_cfg & i_ser_write) begin
         cfg_reg <= i_ser_wdata; // R21 R25
      end else if (rf_wr_hcfg) begin
         cfg_reg[2:0] <= s_wdata[2:0]; // R22
      end else if (rf_wr_pcfg) begin
         cfg_reg[`CFG_PIN_MODE_BIT] <= s_wdata[`CFG_PIN_MODE_BIT]; // R22
      end
   end

   // Harvest enable, power-up default from the stored default-off bit
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         harvest_on_reg <= 1'b0;
      end else if (state_reg == ST_LOAD) begin
         harvest_on_reg <= ~i_nv_config[`CFG_DEF_OFF_BIT]; // R19
      end else if (hit_ctrl & i_ser_write) begin
         harvest_on_reg <= i_ser_wdata[`CTRL_HARVEST_BIT]; // R17
      end else if (rf_set_h) begin
         harvest_on_reg <= s_wdata[`CTRL_HARVEST_BIT]; // R23
      end
   end

   // Write-done flag: success wins over a same-cycle start
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         done_reg <= 1'b0; // R18
      end else if (i_ser_wcycle_ok) begin
         done_reg <= 1'b1; // R18
      end else if (i_ser_wcycle_start) begin
         done_reg <= 1'b0; // R18
      end
   end

   // Serial answer, one cycle after the request
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_ser_ack   <= 1'b0;
         o_ser_err   <= 1'b0;
         o_ser_rdata <= 8'h00;
      end else begin
         o_ser_ack <= i_ser_valid & hit_any & ~lock_ref;
         o_ser_err <= i_ser_valid & (~hit_any | lock_ref); // R1 R3
         if (i_ser_valid & ~i_ser_write) begin
            if (hit_lo) begin
               o_ser_rdata <= lock_reg[7:0]; // R3
            end else if (hit_hi) begin
               o_ser_rdata <= lock_reg[15:8];
            end else if (hit_cfg) begin
               o_ser_rdata <= cfg_reg;
            end else if (hit_ctrl) begin
               o_ser_rdata <= {done_reg, 5'h00, s_field, harvest_on_reg}; // R17 R20
            end else begin
               o_ser_rdata <= 8'h00;
            end
         end
      end
   end

   // RF answer to dedicated commands
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_rf_ack   <= 1'b0;
         o_rf_rdata <= 8'h00;
      end else begin
         o_rf_ack <= rf_cmd;
         if (rf_cmd & (s_cmd == `CMD_READ_CFG)) begin
            o_rf_rdata <= cfg_reg; // R22
         end else if (rf_cmd & (s_cmd == `CMD_READ_CTRL)) begin
            o_rf_rdata <= {1'b0, 5'h00, 1'b1, harvest_on_reg}; // R20 R23 R24
         end
      end
   end

   // Activity pin sequencing
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_LOAD: begin
            state_next = ST_IDLE;
         end
         ST_IDLE: begin
            if (rf_tick & s_field & ~i_ser_active) begin // R11 R13
               if (~pin_mode & s_sof) begin
                  state_next = ST_RX; // R8
               end else if (pin_mode & s_wr_end) begin
                  state_next = ST_WIP; // R12
               end
            end
         end
         ST_RX: begin
            if (~s_field | pin_mode) begin
               state_next = ST_IDLE; // R10
            end else if (rf_tick & s_crc_bad) begin
               state_next = ST_IDLE; // R9
            end else if (rf_tick & s_crc_ok) begin
               state_next = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (~s_field | pin_mode) begin
               state_next = ST_IDLE; // R10
            end else if (rf_tick & s_done) begin
               state_next = ST_IDLE; // R8
            end
         end
         ST_WIP: begin
            if (~s_field | ~pin_mode) begin
               state_next = ST_IDLE; // R10
            end else if (rf_tick & s_ans) begin
               state_next = ST_IDLE; // R12
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= ST_LOAD;
      end else begin
         state_reg <= state_next;
      end
   end

   // Open-drain pin: data always 0, enable pulls low
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_rf_activity_pin_o  <= 1'b0;
         o_rf_activity_pin_oe <= 1'b0;
      end else begin
         o_rf_activity_pin_o  <= 1'b0; // R26
         o_rf_activity_pin_oe <= (state_next == ST_RX) | (state_next == ST_EXEC) |
                                 (state_next == ST_WIP); // R8 R12 R26
      end
   end

   // Harvest gating and sink level; config bits 7:4 unused
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_harvest_drive <= 1'b0;
         o_harvest_level <= 2'b00;
      end else begin
         o_harvest_drive <= harvest_on_reg & s_h_power & s_h_load; // R16
         o_harvest_level <= cfg_reg[`CFG_LVL_HI_BIT:`CFG_LVL_LO_BIT]; // R14 R15
      end
   end

   // Protection and stored-value outputs
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_sector_locked <= 4'h0;
         o_lock_area     <= `LOCK_RESET;
         o_config_byte   <= `CFG_RESET;
      end else begin
         o_sector_locked <= lock_reg[`LOCK_SECTORS-1:0]; // R2
         o_lock_area     <= lock_reg;
         o_config_byte   <= cfg_reg;
      end
   end

endmodule

// [bench/tag_config_and_write_lock_asserts.sv]
`timescale 1ns/1ps
`include "tag_cfg_consts.vh"
module cfg_lock_checker (
   // Clock and reset
   input logic        i_clock,
   input logic        i_rst,
   // Requests and levels
   input logic        i_ser_valid,
   input logic        i_ser_write,
   input logic        i_system_area_select,
   input logic [11:0] i_ser_addr,
   input logic        i_ser_pwd_ok,
   input logic        i_ser_active,
   input logic        i_rf_field,
   input logic        i_harvest_power_ok,
   // Watched outputs
   input logic        o_ser_ack,
   input logic        o_ser_err,
   input logic [7:0]  o_ser_rdata,
   input logic [3:0]  o_sector_locked,
   input logic [15:0] o_lock_area,
   input logic [7:0]  o_config_byte,
   input logic        o_rf_activity_pin_o,
   input logic        o_rf_activity_pin_oe,
   input logic        o_harvest_drive,
   input logic [1:0]  o_harvest_level
);
   // One clock domain
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst);
   // Selected serial request decode
   wire sel_req = i_ser_valid && i_system_area_select;
   wire lock_wr = sel_req && i_ser_write && i_ser_addr[11:1] == 11'h400 && !i_ser_pwd_ok;

   a_sel_refused: assert property (
      i_ser_valid && !i_system_area_select |=> o_ser_err && !o_ser_ack) else $error("no refusal");
   a_lock_guard: assert property (
      $stable(o_lock_area) |-> o_sector_locked == o_lock_area[3:0]) else $error("lock map");
   a_lock_nopwd: assert property (
      lock_wr |=> o_ser_err ##1 $stable(o_lock_area)) else $error("lock write taken");
   a_cfg_open: assert property (
      sel_req && i_ser_addr == `CFG_ADDR |=> o_ser_ack) else $error("config refused");
   a_ctrl_fixed: assert property (
      sel_req && !i_ser_write && i_ser_addr == `CTRL_ADDR |=> o_ser_ack && o_ser_rdata[6:2] == 5'h00)
      else $error("control bits");
   a_pin_drain: assert property (
      o_rf_activity_pin_oe |-> o_rf_activity_pin_o == 1'b0) else $error("pin drives high");
   a_field_cut: assert property (
      !i_rf_field [*6] |-> !o_rf_activity_pin_oe) else $error("pin held without field");
   a_serial_quiet: assert property (
      (i_ser_active && !o_rf_activity_pin_oe) [*6] |=> !o_rf_activity_pin_oe) else $error("pin low");
   a_harvest_gate: assert property (
      !i_harvest_power_ok [*5] |-> !o_harvest_drive) else $error("harvest without power");
   a_level_map: assert property (
      $stable(o_config_byte) |-> o_harvest_level == o_config_byte[1:0]) else $error("level");
   // Main scenarios reached
   c_pin: cover property (o_rf_activity_pin_oe);
   c_drive: cover property (o_harvest_drive);
   c_err: cover property (o_ser_err);
endmodule

bind tag_config_and_write_lock cfg_lock_checker u_chk (.*);

// [bench/rf_engine.sv]
`timescale 1ns/1ps
module rf_engine (
   // Link clock and field
   output logic       o_clk,
   output logic       o_field,
   // Frame events, command, data
   output logic [6:0] o_events,
   output logic [2:0] o_cmd,
   output logic [7:0] o_wdata
);
   // Quiet link: clock parked low outside frames
   initial begin
      o_clk = 1'b0;
      o_field = 1'b0;
      o_events = 7'h00;
      o_cmd = 3'h0;
      o_wdata = 8'h00;
   end
   // Field on or off, off the system edge
   task set_field(input logic v);
      #3 o_field = v;
   endtask
   // Idle bits, then one bit carrying the events
   task step(input logic [6:0] e, input logic [2:0] c, input logic [7:0] d, input int gap);
      #3;
      repeat (gap) begin
         #80 o_clk = 1'b1;
         #80 o_clk = 1'b0;
      end
      o_events = e;
      o_cmd = c;
      o_wdata = d;
      #80 o_clk = 1'b1;
      #80 o_clk = 1'b0;
      // Events drop to zero; command and data lines show inverted values
      o_events = 7'h00;
      o_cmd = ~c;
      o_wdata = ~d;
   endtask
endmodule

// [bench/tag_config_and_write_lock_tb.sv]
`timescale 1ns/1ps
`include "tag_cfg_consts.vh"
module tag_config_and_write_lock_tb;
   // Inputs at time zero
   logic        i_clock = 1'b0;
   logic        i_rst = 1'b1;
   logic [15:0] i_nv_lock = 16'h0000;
   logic [7:0]  i_nv_config = 8'hF4;
   logic        i_ser_valid = 1'b0;
   logic        i_ser_write = 1'b0;
   logic        i_system_area_select = 1'b1;
   logic [11:0] i_ser_addr = 12'h000;
   logic [7:0]  i_ser_wdata = 8'h00;
   logic        i_ser_pwd_ok = 1'b0;
   logic        i_ser_active = 1'b0;
   logic        i_ser_wcycle_start = 1'b0;
   logic        i_ser_wcycle_ok = 1'b0;
   logic        i_harvest_power_ok = 1'b0;
   logic        i_harvest_load_ok = 1'b0;
   // Outputs and link lines
   logic        o_ser_ack, o_ser_err, o_rf_ack, o_harvest_drive, rf_clk, rf_field;
   logic        o_rf_activity_pin_o, o_rf_activity_pin_oe;
   logic [7:0]  o_ser_rdata, o_config_byte, o_rf_rdata, rf_wdata, lk, hc;
   logic [15:0] o_lock_area, re;
   logic [16:0] se;
   logic [6:0]  ev;
   logic [3:0]  o_sector_locked;
   logic [2:0]  rf_cmd;
   logic [1:0]  o_harvest_level;
   // Expected results and tallies
   logic [16:0] ser_q[$];
   logic [15:0] rf_q[$];
   int          fail_count = 0;
   int          checks = 0;
   localparam logic [6:0] SOF = 7'h40, CMD = 7'h21, BAD = 7'h10, DONE = 7'h08;
   localparam logic [6:0] WEND = 7'h04, ANS = 7'h02;
   localparam logic [16:0] WR = 17'h0_0000, ERR = 17'h0_0100;

   always #10 i_clock = ~i_clock;

   tag_config_and_write_lock u_dut (
      .*,
      .i_rf_clk(rf_clk), .i_rf_field(rf_field), .i_rf_sof(ev[6]), .i_rf_crc_ok(ev[5]),
      .i_rf_crc_bad(ev[4]), .i_rf_exec_done(ev[3]), .i_rf_write_end(ev[2]),
      .i_rf_answer_start(ev[1]), .i_rf_cmd_valid(ev[0]), .i_rf_cmd(rf_cmd), .i_rf_wdata(rf_wdata)
   );
   rf_engine u_rf (.o_clk(rf_clk), .o_field(rf_field), .o_events(ev), .o_cmd(rf_cmd), .o_wdata(rf_wdata));

   // Compare and tally
   task check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Verdict
   task final_report;
      if (fail_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   function logic [16:0] rd(input logic [7:0] v, input logic [7:0] m = 8'hFF);
      return {m, 1'b0, v};
   endfunction
   // One serial byte access, note expectation first
   task ser(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [16:0] e);
      ser_q.push_back(e);
      @(posedge i_clock);
      i_ser_valid <= 1'b1;
      i_ser_write <= w;
      i_ser_addr <= a;
      i_ser_wdata <= d;
      @(posedge i_clock);
      i_ser_valid <= 1'b0;
      repeat (2) @(posedge i_clock);
   endtask
   // Write cycle start or good completion pulse
   task wc(input logic ok);
      @(posedge i_clock);
      i_ser_wcycle_ok <= ok;
      i_ser_wcycle_start <= !ok;
      @(posedge i_clock);
      i_ser_wcycle_ok <= 1'b0;
      i_ser_wcycle_start <= 1'b0;
   endtask
   // One link bit; commands note their answer
   task rf(input logic [6:0] e, input logic [2:0] c, input logic [7:0] d, input logic [15:0] x);
      if (e[0]) rf_q.push_back(x);
      u_rf.step(e, c, d, 0);
   endtask
   // Let synchroniser and registers settle
   task settle;
      repeat (4) @(posedge i_clock);
      @(negedge i_clock);
   endtask
   task pin(input logic x);
      settle();
      check("pin", {15'h0000, x}, {15'h0000, o_rf_activity_pin_oe});
   endtask

   // Result watcher
   always @(negedge i_clock) begin
      if (o_ser_ack === 1'b1 || o_ser_err === 1'b1) begin
         se = ser_q.size() > 0 ? ser_q.pop_front() : 17'h1_FEFF;
         check("serial", {6'h00, ~se[8], se[8], se[7:0]},
               {6'h00, o_ser_ack, o_ser_err, o_ser_rdata & se[16:9]});
      end
      if (o_rf_ack === 1'b1) begin
         re = rf_q.size() > 0 ? rf_q.pop_front() : 16'hFFFF;
         check("rf", {8'h00, re[7:0]}, {8'h00, o_rf_rdata & re[15:8]});
      end
   end
   // Hang guard
   initial begin
      #1_500_000;
      fail_count++;
      final_report();
   end

   initial begin
      void'($urandom(53625));
      repeat (8) @(posedge i_clock);
      i_rst <= 1'b0;
      repeat (3) @(posedge i_clock);
      ser(0, `LOCK_LO_ADDR, 8'h00, rd(8'h00));
      ser(0, `LOCK_HI_ADDR, 8'h00, rd(8'h00));
      ser(0, `CFG_ADDR, 8'h00, rd(8'hF4));
      ser(0, `CTRL_ADDR, 8'h00, rd(8'h00));
      ser(1, `LOCK_LO_ADDR, 8'h05, ERR);
      i_system_area_select <= 1'b0;
      ser(0, `CFG_ADDR, 8'h00, ERR);
      i_system_area_select <= 1'b1;
      ser(0, 12'h802, 8'h00, ERR);
      ser(1, 12'h911, 8'h00, ERR);
      i_ser_pwd_ok <= 1'b1;
      lk = 8'($urandom);
      ser(1, `LOCK_LO_ADDR, lk, WR);
      ser(1, `LOCK_HI_ADDR, 8'hFF, WR);
      ser(0, `LOCK_LO_ADDR, 8'h00, rd(lk));
      check("lock area", {8'hFF, lk}, o_lock_area);
      check("locked", {12'h000, lk[3:0]}, {12'h000, o_sector_locked});
      ser(1, `CTRL_ADDR, 8'hFE, WR);
      ser(0, `CTRL_ADDR, 8'h00, rd(8'h00));
      wc(1);
      ser(0, `CTRL_ADDR, 8'h00, rd(8'h80));
      wc(0);
      ser(0, `CTRL_ADDR, 8'h00, rd(8'h00));
      wc(1);
      u_rf.set_field(1);
      settle();
      ser(0, `CTRL_ADDR, 8'h00, rd(8'h82));
      rf(SOF, 3'h0, 8'h00, 0);
      pin(1);
      rf(CMD, `CMD_READ_CFG, 8'h00, {8'hFF, 8'hF4});
      pin(1);
      rf(DONE, 3'h0, 8'h00, 0);
      pin(0);
      rf(SOF, 3'h0, 8'h00, 0);
      rf(BAD, 3'h0, 8'h00, 0);
      pin(0);
      rf(SOF, 3'h0, 8'h00, 0);
      u_rf.set_field(0);
      pin(0);
      u_rf.set_field(1);
      i_ser_active <= 1'b1;
      rf(SOF, 3'h0, 8'h00, 0);
      pin(0);
      i_ser_active <= 1'b0;
      rf(CMD, `CMD_READ_CTRL, 8'h00, {8'hFF, 8'h02});
      for (int c = 0; c < 8; c++) if (c == 0 || c > 5) rf(CMD, 3'(c), 8'hFF, 0);
      hc = 8'($urandom);
      rf(CMD, `CMD_WRITE_HCFG, hc, 0);
      rf(CMD, `CMD_READ_CFG, 8'h00, {8'hFF, 5'h1E, hc[2:0]});
      check("level", {14'h0000, hc[1:0]}, {14'h0000, o_harvest_level});
      ser(1, `CFG_ADDR, {hc[7:4], 4'h2}, WR);
      ser(0, `CFG_ADDR, 8'h00, rd(8'h02, 8'h0F));
      check("config", {8'h00, hc[7:4], 4'h2}, {8'h00, o_config_byte});
      check("level", 16'h0002, {14'h0000, o_harvest_level});
      i_harvest_power_ok <= 1'b1;
      i_harvest_load_ok <= 1'b1;
      rf(CMD, `CMD_SET_HARVEST, 8'h01, 0);
      settle();
      check("drive", 16'h0001, {15'h0000, o_harvest_drive});
      i_harvest_load_ok <= 1'b0;
      settle();
      check("drive", 16'h0000, {15'h0000, o_harvest_drive});
      rf(CMD, `CMD_WRITE_PCFG, 8'hFF, 0);
      rf(SOF, 3'h0, 8'h00, 0);
      pin(0);
      u_rf.step(WEND, 3'h0, 8'h00, 2);
      pin(1);
      rf(ANS, 3'h0, 8'h00, 0);
      pin(0);
      i_ser_active <= 1'b1;
      rf(WEND, 3'h0, 8'h00, 0);
      pin(0);
      i_ser_active <= 1'b0;
      i_rst <= 1'b1;
      i_nv_config <= 8'hF0;
      i_nv_lock <= 16'($urandom);
      repeat (8) @(posedge i_clock);
      i_rst <= 1'b0;
      repeat (3) @(posedge i_clock);
      ser(0, `CTRL_ADDR, 8'h00, rd(8'h03));
      check("locked", {12'h000, i_nv_lock[3:0]}, {12'h000, o_sector_locked});
      for (int i = 0; i < 200 && rf_q.size() + ser_q.size() > 0; i++) @(posedge i_clock);
      if (rf_q.size() + ser_q.size() > 0) check("drain", 16'h0000, 16'h0001);
      final_report();
   end
endmodule
